// *** sim/rss_monitor.sv ***
`default_nettype none
module rss_monitor (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        belowPoweronThreshold,
	input wire logic        watchdogTimeout,
	input wire logic        inSleepOrIdle,
	input wire logic        softResetInstr,
	input wire logic        system_reset_out,
	input wire logic [15:0] reset_cause_register,
	input wire logic        clockReady,
	input wire logic        clock_fail_monitor,
	input wire logic        fetchStart,
	input wire logic [23:0] fetchAddress,
	input wire logic        watchdogWake
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_sleep_timeout;
		$rose(watchdogTimeout) && inSleepOrIdle && !system_reset_out;
	endsequence
	// Core must stay awake through the synchroniser delay
	sequence s_awake_timeout;
		$rose(watchdogTimeout) && !inSleepOrIdle && !system_reset_out
			##1 !inSleepOrIdle [*3];
	endsequence
	a_fetch_after_release: assert property (
		$fell(system_reset_out) |-> ##[0:1] fetchStart)
		else $error("no fetch after release");
	a_fetch_vector: assert property (
		fetchStart |-> fetchAddress == 24'h000000)
		else $error("fetch not at zero");
	a_ready_release: assert property (
		$fell(system_reset_out) |-> clockReady)
		else $error("released before clock ready");
	a_monitor_ready: assert property (
		clock_fail_monitor |-> clockReady)
		else $error("clock monitor before ready");
	a_poweron_flag: assert property (
		belowPoweronThreshold [*3] |-> ##[0:2]
		(system_reset_out && reset_cause_register[0]))
		else $error("low supply not held in reset");
	a_soft_reset: assert property (
		softResetInstr && !system_reset_out |-> ##[1:2]
		(system_reset_out && reset_cause_register[6]) ##[1:3]
		!system_reset_out)
		else $error("soft reset pulse wrong");
	a_wdt_resets: assert property (
		s_awake_timeout |-> ##[0:2]
		(system_reset_out && reset_cause_register[4]))
		else $error("watchdog did not reset");
	a_sleep_wake: assert property (
		s_sleep_timeout |-> ##[1:5] watchdogWake)
		else $error("watchdog did not wake");
	a_sleep_no_reset: assert property (
		s_sleep_timeout ##1 inSleepOrIdle [*4] |-> !system_reset_out)
		else $error("watchdog reset while asleep");
endmodule
bind rss_top rss_monitor u_rss_monitor (.*);
`default_nettype wire

// *** sim/rss_supervisor.sv ***
`default_nettype none
module rss_supervisor (
	input  wire logic clk_sys,
	output var  logic external_reset_pin_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial external_reset_pin_n = 1'b1;
	// Whole cycles only, so filter length is measured exactly
	task automatic hold_low(input int cycles);
		@(posedge clk_sys);
		#1;
		external_reset_pin_n = 1'b0;
		repeat (cycles) @(posedge clk_sys);
		#1;
		external_reset_pin_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** sim/rss_top_bench.sv ***
`default_nettype none
module rss_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic             clk_sys = 0, reset = 1, oscClock = 0;
	logic             belowPoweronThreshold = 1, belowBrownoutThreshold = 1;
	logic             watchdogTimeout = 0, inSleepOrIdle = 0;
	logic             softResetInstr = 0, trapInService = 0;
	logic             trapNewValid = 0, causeWriteEn = 0;
	logic             clockIsCrystal = 1, clockUsesPll = 1;
	logic             clockFailMonitorEnable = 1;
	logic [3:0]       trapServicePrio = 4'hF, trapNewPrio = 4'hD;
	logic [15:0]      remapControl = 16'h0000, remapShadow = 16'h0000;
	logic [15:0]      causeWriteData = 16'h0000;
	logic [2:0]       powerup_delay_select = 3'h1, initial_clock_select = 3'h5;
	wire logic        external_reset_pin_n, system_reset_out, clockReady;
	wire logic        clock_fail_monitor, fetchStart, watchdogWake;
	wire logic [15:0] reset_cause_register;
	wire logic [2:0]  current_clock_select;
	wire logic [23:0] fetchAddress;
	logic [15:0]      mask [5] = '{16'h0040, 16'h0010, 16'h0080,
	                               16'h8000, 16'h0200};
	int               bad_count = 0, total_checks = 0, n;
	rss_top #(.POR_EXT_CYC(25'd10), .BOR_EXT_CYC(25'd20),
		.PLL_LOCK_CYC(25'd30), .CLOCK_FAIL_MONITOR_CYC(25'd40),
		.POWERUP_TIMER_MS_CYC(25'd5)) u_rss_top (.*);
	rss_supervisor u_rss_supervisor (.*);
	initial forever #2 clk_sys = ~clk_sys;
	// Slow enough that every oscillator level is sampled twice
	initial forever #10 oscClock = ~oscClock;
	task automatic tick(input int k = 1);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic ok(input logic c);
		check({23'h0, c}, 24'h1);
	endtask
	task automatic wr(input logic [15:0] d);
		causeWriteData = d;
		causeWriteEn = 1;
		tick();
		causeWriteEn = 0;
	endtask
	// Returns the cycles reset stayed high after it was first seen
	task automatic release_wait(output int hi);
		hi = 0;
		while (system_reset_out !== 1'b1 && hi < 8) begin
			tick();
			hi++;
		end
		hi = 0;
		while (system_reset_out !== 1'b0 && hi < 6000) begin
			tick();
			hi++;
		end
		ok(hi < 6000);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
	initial begin
		tick(20);
		reset = 0;
		tick(5);
		belowPoweronThreshold = 0;
		belowBrownoutThreshold = 0;
		release_wait(n);
		ok(n >= 5170 && n <= 5210);
		ok(fetchStart === 1'b1);
		ok(reset_cause_register[0] === 1'b1);
		check(24'(current_clock_select), 24'h5);
		ok(clock_fail_monitor === 1'b0);
		tick(2);
		ok(fetchAddress === 24'h0);
		tick(45);
		ok(clock_fail_monitor === 1'b1);
		$display("cold start done");
		wr(16'h0050);
		check(24'(reset_cause_register), 24'h50);
		ok(system_reset_out === 1'b0);
		initial_clock_select = 3'h2;
		belowBrownoutThreshold = 1;
		tick(5);
		belowBrownoutThreshold = 0;
		tick(15);
		belowBrownoutThreshold = 1;
		tick(3);
		belowBrownoutThreshold = 0;
		release_wait(n);
		ok(n >= 5180 && n <= 5220);
		check(24'(reset_cause_register), 24'h2);
		check(24'(current_clock_select), 24'h2);
		$display("brown-out done");
		for (int k = 0; k < 5; k++) begin
			wr(16'h0000);
			initial_clock_select = 3'h7;
			softResetInstr = (k == 0);
			watchdogTimeout = (k == 1);
			trapInService = (k == 3);
			trapNewValid = (k == 3);
			remapControl = (k == 4) ? 16'h0100 : 16'h0000;
			if (k == 2)
				u_rss_supervisor.hold_low(12);
			tick();
			ok(k == 1 || system_reset_out === 1'b1);
			softResetInstr = 0;
			tick();
			ok(k != 0 || system_reset_out === 1'b0);
			{watchdogTimeout, trapNewValid, trapInService} = 3'h0;
			remapControl = 16'h0000;
			release_wait(n);
			ok(k != 0 || n <= 3);
			check(24'(reset_cause_register), 24'(mask[k]));
			check(24'(current_clock_select), 24'h2);
		end
		$display("warm sources done");
		wr(16'h0000);
		u_rss_supervisor.hold_low(4);
		inSleepOrIdle = 1;
		watchdogTimeout = 1;
		trapNewPrio = 4'hF;
		{trapInService, trapNewValid} = 2'h3;
		tick(3);
		ok(watchdogWake === 1'b1);
		tick(5);
		ok(system_reset_out === 1'b0);
		check(24'(reset_cause_register[7]), 24'h0);
		check(24'(reset_cause_register[15]), 24'h0);
		{watchdogTimeout, inSleepOrIdle} = 2'h0;
		{trapNewValid, trapInService} = 2'h0;
		ok(clock_fail_monitor === 1'b1);
		clockFailMonitorEnable = 0;
		tick(2);
		ok(clock_fail_monitor === 1'b0);
		$display("refusals done");
		summarize();
	end
endmodule
`default_nettype wire

// *** src/rss_regs.vh ***
`ifndef RSS_REGS_VH
`define RSS_REGS_VH

// System clock period
`define RSS_CLK_NS          25'h4

// Sequencing times, in ns, sized to the cycle counters
`define RSS_POR_EXT_NS      25'h7530
`define RSS_BOR_EXT_NS      25'h186A0
`define RSS_PLL_LOCK_NS     25'h16E360
`define RSS_CLOCK_FAIL_MONITOR_NS         25'hDBBA0
`define RSS_POWERUP_TIMER_STEP_NS    25'hF4240

// Oscillator start-up timer length, in oscillator periods
`define RSS_OST_PERIODS     11'h400

// External pin glitch filter length, in system clocks
`define RSS_PIN_FILTER_CYC  4'h8

// Hard trap priority window
`define RSS_HARD_TRAP_LO    4'hD
`define RSS_HARD_TRAP_HI    4'hF

// Reset cause register bit positions
`define RSS_BIT_POR         0
`define RSS_BIT_BOR         1
`define RSS_BIT_WATCHDOG_TIMEOUT_FLAG        4
`define RSS_BIT_SWR         6
`define RSS_BIT_PIN_RESET_FLAG        7
`define RSS_BIT_CM          9
`define RSS_BIT_TRAP_CONFLICT_FLAG       15

// Implemented cause bits and reset value
`define RSS_CAUSE_MASK      16'h82D3
`define RSS_CAUSE_RESET     16'h0003

// Reset vector and clock select after logic reset
`define RSS_RESET_VECTOR    24'h000000
`define RSS_CLKSEL_RESET    3'h0

// Width of the pin-remapping control compare
`define RSS_REMAP_W         16

`endif

// *** src/rss_top.v ***
// What this block does
// [RULE1] Crystal clock waits 1024 oscillator periods
// [RULE2] PLL clock additionally waits lock time
// [RULE3] Hold reset until ready, fetch at zero
// [RULE4] Clock monitor starts after ready plus delay
// [RULE5] Power-on reset held threshold plus extension
// [RULE6] Power-on event sets power-on flag
// [RULE7] Brown-out held until threshold plus extension
// [RULE8] Brown-out event sets brown-out flag
// [RULE9] Three-bit field selects power-up delay
// [RULE10] Each supply rise restarts whole delay
// [RULE11] Filtered low pin pulses cause reset
// [RULE12] Pin reset sets pin-reset flag
// [RULE13] Reset instruction: one-cycle warm reset
// [RULE14] Reset instruction sets soft-reset flag
// [RULE15] Watchdog time-out resets, clock kept
// [RULE16] Watchdog in sleep/idle only wakes
// [RULE17] Watchdog time-out sets its flag
// [RULE18] Lower hard trap during trap: reset
// [RULE19] Trap conflict sets trap-conflict flag
// [RULE20] Remap registers compared against shadow copies
// [RULE21] Mismatch reset sets mismatch flag
// [RULE22] Any source asserts system reset
// [RULE23] Cold reset loads clock select; warm keeps
// [RULE24] Power-on clears other flags; software writes
// [RULE25] Async sources synchronised before flag update
`include "rss_regs.vh"
`default_nettype none

module rss_top #(
	parameter [24:0] POR_EXT_CYC  = `RSS_POR_EXT_NS / `RSS_CLK_NS,
	parameter [24:0] BOR_EXT_CYC  = `RSS_BOR_EXT_NS / `RSS_CLK_NS,
	parameter [24:0] PLL_LOCK_CYC = `RSS_PLL_LOCK_NS / `RSS_CLK_NS,
	parameter [24:0] CLOCK_FAIL_MONITOR_CYC     = `RSS_CLOCK_FAIL_MONITOR_NS / `RSS_CLK_NS,
	parameter [24:0] POWERUP_TIMER_MS_CYC  = `RSS_POWERUP_TIMER_STEP_NS / `RSS_CLK_NS
) (
	input  wire                    clk_sys,
	input  wire                    reset,
	input  wire                    belowPoweronThreshold,
	input  wire                    belowBrownoutThreshold,
	input  wire                    external_reset_pin_n,
	input  wire                    oscClock,
	input  wire                    watchdogTimeout,
	input  wire                    inSleepOrIdle,
	input  wire                    softResetInstr,
	input  wire                    trapInService,
	input  wire [3:0]              trapServicePrio,
	input  wire                    trapNewValid,
	input  wire [3:0]              trapNewPrio,
	input  wire [`RSS_REMAP_W-1:0] remapControl,
	input  wire [`RSS_REMAP_W-1:0] remapShadow,
	input  wire                    clockIsCrystal,
	input  wire                    clockUsesPll,
	input  wire                    clockFailMonitorEnable,
	input  wire [2:0]              powerup_delay_select,
	input  wire [2:0]              initial_clock_select,
	input  wire                    causeWriteEn,
	input  wire [15:0]             causeWriteData,
	output reg                     system_reset_out,
	output reg  [15:0]             reset_cause_register,
	output reg  [2:0]              current_clock_select,
	output reg                     clockReady,
	output reg                     clock_fail_monitor,
	output reg                     fetchStart,
	output reg  [23:0]             fetchAddress,
	output reg                     watchdogWake
);

	localparam [2:0] ST_SUPPLY = 3'h0;
	localparam [2:0] ST_EXT    = 3'h1;
	localparam [2:0] ST_POWERUP_TIMER   = 3'h2;
	localparam [2:0] ST_OST    = 3'h3;
	localparam [2:0] ST_LOCK   = 3'h4;
	localparam [2:0] ST_RUN    = 3'h5;
	localparam [2:0] ST_WARM   = 3'h6;

	// Async order: por, bor, pin, watchdog, oscillator
	localparam [4:0] SYNC_RESET = 5'h07;

	function [24:0] pwrtCycles;
		input [2:0] sel;
		begin
			if (sel == 3'h0)
				pwrtCycles = 25'h0;
			else
				pwrtCycles = POWERUP_TIMER_MS_CYC << sel;
		end
	endfunction

	wire [4:0] asyncIn = {oscClock, watchdogTimeout,
		external_reset_pin_n, belowBrownoutThreshold,
		belowPoweronThreshold};

	reg  [4:0]  meta_ff;
	reg  [4:0]  sync_ff;
	reg  [4:0]  prev_ff;
	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg  [24:0] cnt_ff;
	reg  [24:0] nxt_cnt;
	reg         coldPor_ff;
	reg         nxt_coldPor;
	reg  [3:0]  pinFilt_ff;
	reg         pinReq_ff;
	reg  [24:0] fscmCnt_ff;
	reg  [15:0] nxt_cause;
	reg         nxt_system_reset_out;

	// Two flops per async source before any logic looks at it
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
			always @(posedge clk_sys) begin
				if (reset) begin
					meta_ff[gi] <= SYNC_RESET[gi];
					sync_ff[gi] <= SYNC_RESET[gi];
					prev_ff[gi] <= SYNC_RESET[gi];
				end else begin
					meta_ff[gi] <= asyncIn[gi]; // [RULE25]
					sync_ff[gi] <= meta_ff[gi];
					prev_ff[gi] <= sync_ff[gi];
				end
			end
		end
	endgenerate

	wire porLvl  = sync_ff[0];
	wire borLvl  = sync_ff[1] & ~sync_ff[0];
	wire pinLow  = ~sync_ff[2];
	wire wdtEdge = sync_ff[3] & ~prev_ff[3];
	wire oscEdge = sync_ff[4] & ~prev_ff[4];
	wire porEvt  = sync_ff[0] & ~prev_ff[0];
	wire borEvt  = borLvl & ~(prev_ff[1] & ~prev_ff[0]);
	wire running = (state_ff == ST_RUN);

	// Filter turns short low glitches on the pin into nothing
	always @(posedge clk_sys) begin
		if (reset) begin
			pinFilt_ff <= 4'h0;
			pinReq_ff  <= 1'b0;
		end else if (!pinLow) begin
			pinFilt_ff <= 4'h0;
			pinReq_ff  <= 1'b0;
		end else if (pinFilt_ff == `RSS_PIN_FILTER_CYC) begin
			pinReq_ff <= 1'b1; // [RULE11]
		end else begin
			pinFilt_ff <= pinFilt_ff + 4'h1;
		end
	end

	wire pinEvt  = pinLow && (pinFilt_ff == `RSS_PIN_FILTER_CYC) &&
		!pinReq_ff;
	// Synchronised, so a time-out resets two clocks late
	wire wdtRst  = wdtEdge && !inSleepOrIdle; // [RULE15] [RULE16]
	wire trapCfl = trapNewValid && trapInService &&
		(trapNewPrio >= `RSS_HARD_TRAP_LO) &&
		(trapNewPrio <= `RSS_HARD_TRAP_HI) &&
		(trapNewPrio < trapServicePrio); // [RULE18]
	wire cfgMis  = (remapControl != remapShadow); // [RULE20]
	wire swRst   = softResetInstr && running;
	wire warmAny = pinEvt || pinReq_ff || swRst || wdtRst ||
		trapCfl || cfgMis;

	always @* begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_coldPor = coldPor_ff;
		if (porLvl || borLvl) begin
			// Any supply dip restarts the whole chain
			nxt_state   = ST_SUPPLY; // [RULE10]
			nxt_cnt     = 25'h0;
			nxt_coldPor = porLvl | (coldPor_ff & ~borEvt);
		end else begin
			case (state_ff)
			ST_SUPPLY: begin
				nxt_state = ST_EXT;
				nxt_cnt   = 25'h0;
			end
			ST_EXT: begin
				if (cnt_ff >= (coldPor_ff ? POR_EXT_CYC :
					BOR_EXT_CYC)) begin // [RULE5] [RULE7]
					nxt_state = ST_POWERUP_TIMER;
					nxt_cnt   = 25'h0;
				end else
					nxt_cnt = cnt_ff + 25'h1;
			end
			ST_POWERUP_TIMER: begin
				if (cnt_ff >= pwrtCycles(powerup_delay_select)) begin
					nxt_state = ST_OST; // [RULE9]
					nxt_cnt   = 25'h0;
				end else
					nxt_cnt = cnt_ff + 25'h1;
			end
			ST_OST: begin
				if (!clockIsCrystal ||
					cnt_ff >= {14'h0, `RSS_OST_PERIODS}) begin
					nxt_state = ST_LOCK; // [RULE1]
					nxt_cnt   = 25'h0;
				end else if (oscEdge)
					nxt_cnt = cnt_ff + 25'h1;
			end
			ST_LOCK: begin
				if (!clockUsesPll || cnt_ff >= PLL_LOCK_CYC) begin
					nxt_state = ST_RUN; // [RULE2] [RULE3]
					nxt_cnt   = 25'h0;
				end else
					nxt_cnt = cnt_ff + 25'h1;
			end
			ST_RUN: begin
				if (warmAny)
					nxt_state = ST_WARM; // [RULE22]
			end
			ST_WARM: begin
				// Clock is not restarted: back to running directly
				if (!warmAny && !pinLow)
					nxt_state = ST_RUN; // [RULE13]
			end
			default: begin
				nxt_state = ST_SUPPLY;
				nxt_cnt   = 25'h0;
			end
			endcase
		end
		nxt_system_reset_out = (nxt_state != ST_RUN); // [RULE22]
	end

	// Event sets are applied after a software write so they win
	always @* begin
		nxt_cause = reset_cause_register;
		if (causeWriteEn)
			nxt_cause = causeWriteData & `RSS_CAUSE_MASK; // [RULE24]
		if (porEvt) begin
			nxt_cause = 16'h0;
			nxt_cause[`RSS_BIT_POR] = 1'b1; // [RULE6] [RULE24]
		end
		if (borEvt) begin
			nxt_cause[`RSS_BIT_TRAP_CONFLICT_FLAG] = 1'b0;
			nxt_cause[`RSS_BIT_CM]    = 1'b0;
			nxt_cause[`RSS_BIT_SWR]   = 1'b0;
			nxt_cause[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b0;
			nxt_cause[`RSS_BIT_BOR]   = 1'b1; // [RULE8]
		end
		if (pinEvt)
			nxt_cause[`RSS_BIT_PIN_RESET_FLAG] = 1'b1; // [RULE12]
		if (swRst)
			nxt_cause[`RSS_BIT_SWR] = 1'b1; // [RULE14]
		if (wdtEdge)
			nxt_cause[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1; // [RULE17]
		if (trapCfl && running)
			nxt_cause[`RSS_BIT_TRAP_CONFLICT_FLAG] = 1'b1; // [RULE19]
		if (cfgMis && running)
			nxt_cause[`RSS_BIT_CM] = 1'b1; // [RULE21]
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			state_ff             <= ST_SUPPLY;
			cnt_ff               <= 25'h0;
			coldPor_ff           <= 1'b1;
			system_reset_out     <= 1'b1;
			reset_cause_register <= `RSS_CAUSE_RESET;
			current_clock_select <= `RSS_CLKSEL_RESET;
			clockReady           <= 1'b0;
			fetchStart           <= 1'b0;
			fetchAddress         <= `RSS_RESET_VECTOR;
			watchdogWake         <= 1'b0;
		end else begin
			state_ff             <= nxt_state;
			cnt_ff               <= nxt_cnt;
			coldPor_ff           <= nxt_coldPor;
			system_reset_out     <= nxt_system_reset_out;
			reset_cause_register <= nxt_cause;
			// Only cold resets reload the clock choice
			if (nxt_state == ST_SUPPLY)
				current_clock_select <= initial_clock_select; // [RULE23]
			if (nxt_state == ST_SUPPLY)
				clockReady <= 1'b0;
			else if (state_ff == ST_LOCK && nxt_state == ST_RUN)
				clockReady <= 1'b1;
			fetchStart   <= system_reset_out && !nxt_system_reset_out; // [RULE3]
			fetchAddress <= `RSS_RESET_VECTOR;
			watchdogWake <= wdtEdge && inSleepOrIdle; // [RULE16]
		end
	end

	// Monitor arms only after the clock has settled for its delay
	always @(posedge clk_sys) begin
		// Dropped with clock ready, so it never outlives it
		if (reset || !clockReady || nxt_state == ST_SUPPLY) begin
			fscmCnt_ff         <= 25'h0;
			clock_fail_monitor <= 1'b0;
		end else if (fscmCnt_ff >= CLOCK_FAIL_MONITOR_CYC) begin
			clock_fail_monitor <= clockFailMonitorEnable; // [RULE4]
		end else begin
			fscmCnt_ff <= fscmCnt_ff + 25'h1;
		end
	end

endmodule

`default_nettype wire
